// *** logic/pwr_cfg.svh ***
`ifndef PWR_CFG_SVH
`define PWR_CFG_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define PWR_CTRL_OFS 8'h00
`define PWR_STAT_OFS 8'h04
`define PWR_BKP_OFS 8'h40
`define PWR_BKP_WORDS 20

// ****************************************************************
// Control register fields
// ****************************************************************
`define PWR_CTRL_MODE_LSB 0
`define PWR_CTRL_LOWREG_BIT 2
`define PWR_CTRL_RET_BIT 3
`define PWR_CTRL_ENTER_BIT 8

// ****************************************************************
// Status register fields
// ****************************************************************
`define PWR_STAT_STATE_LSB 0
`define PWR_STAT_WSB_BIT 3
`define PWR_STAT_WSTOP_BIT 4
`define PWR_STAT_BAT_BIT 5
`define PWR_STAT_REGDIS_BIT 6
`define PWR_STAT_DBG_BIT 7

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define PWR_CTRL_MODE_RST 2'h0
`define PWR_RESTART_TIME_NS 100
`define PWR_CLK_PERIOD_PS 5000

`endif

// *** logic/pwr_pkg.sv ***
package pwr_pkg;

  // ****************************************************************
  // Power states and requested modes
  // ****************************************************************
  typedef enum logic [2:0] {
    PS_RUN = 3'b000,
    PS_SLEEP = 3'b001,
    PS_STOP = 3'b010,
    PS_STANDBY = 3'b011,
    PS_RESTART = 3'b100,
    PS_BATTERY = 3'b101
  } pwr_state_e;

  typedef enum logic [1:0] {
    MODE_SLEEP = 2'b00,
    MODE_STOP = 2'b01,
    MODE_STANDBY = 2'b10
  } lp_mode_e;

  // ****************************************************************
  // Controller state
  // ****************************************************************
  typedef struct packed {
    pwr_state_e state;
    logic [1:0] mode_sel;
    logic lp_reg_sel;
    logic sram_retain;
    logic wake_sb;
    logic wake_stop;
    logic [7:0] cnt;
    logic wake_pin_prev;
    logic ack;
    logic bkp_hit;
    logic [31:0] dat;
  } ctl_state_s;

endpackage

// *** logic/bkp_if.sv ***
`timescale 1ns/1ps

interface bkp_if;
  logic [4:0] idx;
  logic [3:0] we;
  logic [31:0] wdata;
  logic [31:0] rdata;

  modport ctl (output idx, output we, output wdata, input rdata);
  modport mem (input idx, input we, input wdata, output rdata);
endinterface

// *** logic/bkp_store.sv ***
`timescale 1ns/1ps

module bkp_store #(
  parameter int WORDS = 20
) (
  input wire logic clk_i,
  bkp_if.mem port
);

  // ****************************************************************
  // Retained words: no reset of any kind touches them
  // ****************************************************************
  logic [31:0] mem [WORDS];
  logic [31:0] rdata;

  always_ff @(posedge clk_i) begin
    for (int b = 0; b < 4; b++) begin
      if (port.we[b] && int'(port.idx) < WORDS) begin
        mem[port.idx][b*8 +: 8] <= port.wdata[b*8 +: 8];
      end
    end
    if (int'(port.idx) < WORDS) begin
      rdata <= mem[port.idx];
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  assign port.rdata = rdata;

endmodule // bkp_store

// *** logic/low_power_mode_wakeup_ctrl.sv ***
`timescale 1ns/1ps
`include "pwr_cfg.svh"

// Function
// - Sleep halts only the processor; peripheral clocks keep running
// - Any peripheral interrupt or event wakes the processor from Sleep
// - Stop gates core clocks and disables PLL and both fast oscillators
// - Stop keeps register contents, backup SRAM only if enabled; no reset on Stop exit
// - In Stop the regulator runs main or low-power mode as selected
// - Any external event line source wakes the device from Stop
// - Low-power regulator setting applies only while entering Stop
// - Regulator power-down occurs only on Standby entry
// - Standby switches off regulator, core power, PLL and oscillators
// - Standby loses core state; backup registers kept, SRAM if enabled
// - Standby exits on reset pin, watchdog, wake pin rise, calendar
// - Calendar, watchdog and slow clocks keep running in Stop/Standby
// - Backup store holds 80 bytes as 32-bit words
// - Backup words survive system reset, power reset and Standby
// - Backup supply comes from main supply, else battery pin
// - On battery alone, interrupts and calendar events do not exit
// - Regulator-disable pin high switches off the internal regulator
// - With regulator off, core reset pin is only core power-on reset
// - Core reset pin low with regulator off blocks debug at reset
// - Internal-reset-disable pin high removes battery function

module low_power_mode_wakeup_ctrl #(
  parameter int BKP_WORDS = `PWR_BKP_WORDS
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  input wire logic [3:0] SEL_I,
  input wire logic WE_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  output logic ACK_O,
  input wire logic PERIPH_EVENT_I,
  input wire logic [15:0] EXT_LINE_I,
  input wire logic SUPPLY_DET_I,
  input wire logic CAL_ALARM_I,
  input wire logic CAL_WAKE_I,
  input wire logic CAL_TAMPER_I,
  input wire logic CAL_STAMP_I,
  input wire logic USB_WAKE_I,
  input wire logic ETH_WAKE_I,
  input wire logic EXT_RESET_PIN_N_I,
  input wire logic WDOG_RESET_I,
  input wire logic WAKEUP_PIN_I,
  input wire logic REG_DISABLE_PIN_I,
  input wire logic CORE_RESET_PIN_N_I,
  input wire logic INT_RESET_DISABLE_PIN_I,
  input wire logic MAIN_SUPPLY_OK_I,
  output logic CPU_HALT_O,
  output logic PERIPH_CLK_EN_O,
  output logic CORE_CLK_EN_O,
  output logic PLL_EN_O,
  output logic INT_OSC_EN_O,
  output logic EXT_OSC_EN_O,
  output logic SLOW_CLK_EN_O,
  output logic CAL_RUN_O,
  output logic WDOG_RUN_O,
  output logic REG_ENABLE_O,
  output logic REG_MAIN_O,
  output logic REG_LOWPOWER_O,
  output logic REG_POWERDOWN_O,
  output logic CORE_POWER_EN_O,
  output logic CORE_RESET_O,
  output logic BKP_SRAM_RETAIN_O,
  output logic BKP_FROM_BAT_O,
  output logic BAT_MODE_O,
  output logic CORE_PIN_GPIO_EN_O,
  output logic DEBUG_EN_O
);

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int RESTART_CYCLES = (`PWR_RESTART_TIME_NS * 1000
    + `PWR_CLK_PERIOD_PS - 1) / `PWR_CLK_PERIOD_PS;
  localparam logic [7:0] RESTART_LAST = 8'(RESTART_CYCLES - 1);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic is_bkp(input logic [7:0] adr);
    return adr >= `PWR_BKP_OFS &&
      adr < 8'(`PWR_BKP_OFS + 4 * BKP_WORDS);
  endfunction

  function automatic logic [4:0] bkp_idx(input logic [7:0] adr);
    logic [7:0] rel;
    rel = adr - `PWR_BKP_OFS;
    return rel[6:2];
  endfunction

  // ****************************************************************
  // State and combined inputs
  // ****************************************************************
  pwr_pkg::ctl_state_s s;
  pwr_pkg::ctl_state_s next_s;
  bkp_if bkp ();
  logic force_rst;
  logic bat_mode;
  logic stop_src;
  logic cal_evt;
  logic sb_src;
  logic req;
  logic wr;
  logic [31:0] stat_word;
  logic [31:0] ctrl_word;

  assign req = CYC_I && STB_I;
  assign wr = req && WE_I && s.ack;
  assign force_rst = !EXT_RESET_PIN_N_I || WDOG_RESET_I;
  assign cal_evt = CAL_ALARM_I || CAL_WAKE_I || CAL_TAMPER_I || CAL_STAMP_I;
  assign stop_src = |EXT_LINE_I || SUPPLY_DET_I || cal_evt ||
    USB_WAKE_I || ETH_WAKE_I;
  assign sb_src = force_rst || (WAKEUP_PIN_I && !s.wake_pin_prev) ||
    cal_evt;
  assign bat_mode = !MAIN_SUPPLY_OK_I && !INT_RESET_DISABLE_PIN_I;

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[`PWR_CTRL_MODE_LSB +: 2] = s.mode_sel;
    ctrl_word[`PWR_CTRL_LOWREG_BIT] = s.lp_reg_sel;
    ctrl_word[`PWR_CTRL_RET_BIT] = s.sram_retain;
    stat_word = 32'h0000_0000;
    stat_word[`PWR_STAT_STATE_LSB +: 3] = s.state;
    stat_word[`PWR_STAT_WSB_BIT] = s.wake_sb;
    stat_word[`PWR_STAT_WSTOP_BIT] = s.wake_stop;
    stat_word[`PWR_STAT_BAT_BIT] = bat_mode;
    stat_word[`PWR_STAT_REGDIS_BIT] = REG_DISABLE_PIN_I;
    stat_word[`PWR_STAT_DBG_BIT] = DEBUG_EN_O;
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_s = s;
    next_s.wake_pin_prev = WAKEUP_PIN_I;
    next_s.ack = req && !s.ack;
    next_s.bkp_hit = is_bkp(ADR_I);
    next_s.dat = 32'h0000_0000;
    if (req && !s.ack && !WE_I) begin
      if (ADR_I == `PWR_CTRL_OFS) begin
        next_s.dat = ctrl_word;
      end else if (ADR_I == `PWR_STAT_OFS) begin
        next_s.dat = stat_word;
      end
    end
    // Writes land on the edge that sees ack high
    if (wr && ADR_I == `PWR_CTRL_OFS && SEL_I[0]) begin
      next_s.mode_sel = DAT_I[`PWR_CTRL_MODE_LSB +: 2];
      next_s.lp_reg_sel = DAT_I[`PWR_CTRL_LOWREG_BIT];
      next_s.sram_retain = DAT_I[`PWR_CTRL_RET_BIT];
    end
    if (wr && ADR_I == `PWR_STAT_OFS && SEL_I[0]) begin
      if (DAT_I[`PWR_STAT_WSB_BIT]) begin
        next_s.wake_sb = 1'b0;
      end
      if (DAT_I[`PWR_STAT_WSTOP_BIT]) begin
        next_s.wake_stop = 1'b0;
      end
    end
    case (s.state)
      pwr_pkg::PS_RUN: begin
        if (wr && ADR_I == `PWR_CTRL_OFS && SEL_I[1] &&
            DAT_I[`PWR_CTRL_ENTER_BIT]) begin
          case (pwr_pkg::lp_mode_e'(DAT_I[`PWR_CTRL_MODE_LSB +: 2]))
            pwr_pkg::MODE_SLEEP: next_s.state = pwr_pkg::PS_SLEEP;
            pwr_pkg::MODE_STOP: next_s.state = pwr_pkg::PS_STOP;
            pwr_pkg::MODE_STANDBY: next_s.state = pwr_pkg::PS_STANDBY;
            default: next_s.state = pwr_pkg::PS_RUN;
          endcase
        end
      end
      pwr_pkg::PS_SLEEP: begin
        if (PERIPH_EVENT_I) begin
          next_s.state = pwr_pkg::PS_RUN;
        end
      end
      pwr_pkg::PS_STOP: begin
        if (stop_src) begin
          next_s.state = pwr_pkg::PS_RUN;
          next_s.wake_stop = 1'b1;
        end
      end
      pwr_pkg::PS_STANDBY: begin
        if (sb_src) begin
          next_s.state = pwr_pkg::PS_RESTART;
          next_s.cnt = 8'h00;
          next_s.wake_sb = 1'b1;
        end
      end
      pwr_pkg::PS_RESTART: begin
        if (s.cnt == RESTART_LAST) begin
          next_s.state = pwr_pkg::PS_RUN;
        end else begin
          next_s.cnt = s.cnt + 8'h01;
        end
      end
      pwr_pkg::PS_BATTERY: begin
        if (!bat_mode) begin
          next_s.state = pwr_pkg::PS_RESTART;
          next_s.cnt = 8'h00;
        end
      end
      default: next_s.state = pwr_pkg::PS_RESTART;
    endcase
    // Resets outrank wake handling; battery outranks everything
    if (force_rst && s.state != pwr_pkg::PS_BATTERY) begin
      next_s.state = pwr_pkg::PS_RESTART;
      next_s.cnt = 8'h00;
    end
    if (bat_mode) begin
      next_s.state = pwr_pkg::PS_BATTERY;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      s.state <= pwr_pkg::PS_RESTART;
      s.wake_pin_prev <= 1'b0;
      s.mode_sel <= `PWR_CTRL_MODE_RST;
      s.lp_reg_sel <= 1'b0;
      s.sram_retain <= 1'b0;
      s.wake_sb <= 1'b0;
      s.wake_stop <= 1'b0;
      s.cnt <= 8'h00;
      s.ack <= 1'b0;
      s.bkp_hit <= 1'b0;
      s.dat <= 32'h0000_0000;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Backup store
  // ****************************************************************
  assign bkp.idx = bkp_idx(ADR_I);
  assign bkp.we = (wr && is_bkp(ADR_I)) ? SEL_I : 4'h0;
  assign bkp.wdata = DAT_I;

  bkp_store #(.WORDS(BKP_WORDS)) u_store (
    .clk_i(CLK_I),
    .port(bkp.mem)
  );

  assign ACK_O = s.ack;
  assign DAT_O = s.bkp_hit ? bkp.rdata : s.dat;

  // ****************************************************************
  // Power and clock controls
  // ****************************************************************
  logic deep;
  assign deep = s.state == pwr_pkg::PS_STOP ||
    s.state == pwr_pkg::PS_STANDBY || s.state == pwr_pkg::PS_BATTERY;

  assign CPU_HALT_O = s.state != pwr_pkg::PS_RUN;
  assign PERIPH_CLK_EN_O = !deep;
  assign CORE_CLK_EN_O = !deep;
  assign PLL_EN_O = !deep;
  assign INT_OSC_EN_O = !deep;
  assign EXT_OSC_EN_O = !deep;
  assign SLOW_CLK_EN_O = 1'b1;
  assign CAL_RUN_O = 1'b1;
  assign WDOG_RUN_O = 1'b1;
  assign REG_ENABLE_O = !REG_DISABLE_PIN_I;
  assign REG_LOWPOWER_O = REG_ENABLE_O && s.state == pwr_pkg::PS_STOP &&
    s.lp_reg_sel;
  assign REG_POWERDOWN_O = REG_ENABLE_O &&
    s.state == pwr_pkg::PS_STANDBY;
  assign REG_MAIN_O = REG_ENABLE_O && !REG_LOWPOWER_O &&
    !REG_POWERDOWN_O && s.state != pwr_pkg::PS_BATTERY;
  assign CORE_POWER_EN_O = s.state != pwr_pkg::PS_STANDBY &&
    s.state != pwr_pkg::PS_BATTERY;
  assign CORE_RESET_O = s.state == pwr_pkg::PS_STANDBY ||
    s.state == pwr_pkg::PS_RESTART || s.state == pwr_pkg::PS_BATTERY ||
    (REG_DISABLE_PIN_I && !CORE_RESET_PIN_N_I);
  assign BKP_SRAM_RETAIN_O = !deep || s.sram_retain;
  assign BKP_FROM_BAT_O = bat_mode;
  assign BAT_MODE_O = s.state == pwr_pkg::PS_BATTERY;
  assign CORE_PIN_GPIO_EN_O = !REG_DISABLE_PIN_I;
  assign DEBUG_EN_O = !(REG_DISABLE_PIN_I && !CORE_RESET_PIN_N_I);

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_sleep_wake: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    s.state == pwr_pkg::PS_SLEEP && PERIPH_EVENT_I && !force_rst &&
    !bat_mode |=> s.state == pwr_pkg::PS_RUN && !CPU_HALT_O)
    else $error("sleep did not wake on event");

  a_sleep_periph: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    s.state == pwr_pkg::PS_SLEEP |-> CPU_HALT_O && PERIPH_CLK_EN_O &&
    CORE_CLK_EN_O)
    else $error("sleep stopped more than the processor");

  a_stop_clocks: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    s.state == pwr_pkg::PS_STOP |-> !CORE_CLK_EN_O && !PLL_EN_O &&
    !INT_OSC_EN_O && !EXT_OSC_EN_O && CORE_POWER_EN_O)
    else $error("stop left a fast clock running");

  a_stop_regsel: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    s.state == pwr_pkg::PS_STOP && REG_ENABLE_O |->
    REG_LOWPOWER_O == s.lp_reg_sel &&
    REG_MAIN_O == !s.lp_reg_sel)
    else $error("stop regulator mode wrong");

  a_lpr_only_stop: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    REG_LOWPOWER_O |-> s.state == pwr_pkg::PS_STOP)
    else $error("low-power regulator outside stop");

  a_stop_wake: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    s.state == pwr_pkg::PS_STOP && stop_src && !force_rst && !bat_mode
    |=> s.state == pwr_pkg::PS_RUN && s.wake_stop)
    else $error("stop ignored wake source");

  a_pd_standby: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    REG_POWERDOWN_O |-> s.state == pwr_pkg::PS_STANDBY &&
    !CORE_POWER_EN_O && !PLL_EN_O)
    else $error("power-down outside standby");

  a_standby_exit: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    s.state == pwr_pkg::PS_STANDBY && $rose(WAKEUP_PIN_I) && !bat_mode
    |=> s.state == pwr_pkg::PS_RESTART ##1 CORE_RESET_O)
    else $error("standby missed wake pin rise");

  a_restart_len: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    $past(s.state) == pwr_pkg::PS_RESTART && s.state == pwr_pkg::PS_RUN
    |-> $past(s.cnt) == RESTART_LAST)
    else $error("restart sequence cut short");

  a_bat_hold: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    s.state == pwr_pkg::PS_BATTERY && bat_mode && cal_evt
    |=> s.state == pwr_pkg::PS_BATTERY)
    else $error("battery mode left on event");

  a_slow_run: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    deep |-> SLOW_CLK_EN_O && CAL_RUN_O && WDOG_RUN_O)
    else $error("slow clock domain stopped");

  a_regulator_disable_pin_pins: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    REG_DISABLE_PIN_I |-> !REG_ENABLE_O && !CORE_PIN_GPIO_EN_O &&
    (CORE_RESET_PIN_N_I || (CORE_RESET_O && !DEBUG_EN_O)))
    else $error("regulator-off pin handling wrong");

  a_no_bat_irr: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    INT_RESET_DISABLE_PIN_I |-> !BKP_FROM_BAT_O)
    else $error("battery used with reset disable pin");

endmodule // low_power_mode_wakeup_ctrl

// *** tb/pwr_partner.sv ***
`timescale 1ns/1ps

// ****************************************************************
// Wake sources and reset supervisor
// ****************************************************************
module pwr_partner (
  input wire logic clk_i,
  output logic periph_event_o,
  output logic [15:0] ext_line_o,
  output logic supply_det_o,
  output logic cal_alarm_o,
  output logic cal_wake_o,
  output logic cal_tamper_o,
  output logic cal_stamp_o,
  output logic usb_wake_o,
  output logic eth_wake_o,
  output logic ext_reset_n_o,
  output logic wdog_reset_o,
  output logic wakeup_pin_o,
  output logic core_reset_n_o
);
  logic [26:0] ev = 27'h0;
  logic core_n = 1'b1;

  assign {periph_event_o, wakeup_pin_o, wdog_reset_o} = ev[26:24];
  assign ext_reset_n_o = ~ev[23];
  assign {eth_wake_o, usb_wake_o, cal_stamp_o, cal_tamper_o, cal_wake_o,
    cal_alarm_o, supply_det_o, ext_line_o} = ev[22:0];
  // Core reset pin driven apart from the external reset pin
  assign core_reset_n_o = core_n;

  // One-cycle pulse on source n
  task automatic pulse(input int n);
    @(posedge clk_i) ev <= 27'h1 << n;
    @(posedge clk_i) ev <= 27'h0;
  endtask

  task automatic hold_core(input logic lvl);
    @(posedge clk_i) core_n <= lvl;
  endtask
endmodule // pwr_partner

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`include "pwr_cfg.svh"

module testbench;
  logic CLK_I = 1'b0;
  logic SYS_RST_I = 1'b1;
  logic WE_I = 1'b0;
  logic CYC_I = 1'b0;
  logic STB_I = 1'b0;
  logic [7:0] ADR_I = 8'h00;
  logic [31:0] DAT_I = 32'h0;
  logic [3:0] SEL_I = 4'h0;
  logic REG_DISABLE_PIN_I = 1'b0;
  logic INT_RESET_DISABLE_PIN_I = 1'b0;
  logic MAIN_SUPPLY_OK_I = 1'b1;
  logic [31:0] DAT_O;
  logic [15:0] EXT_LINE_I;
  logic ACK_O, PERIPH_EVENT_I, SUPPLY_DET_I, CAL_ALARM_I, CAL_WAKE_I;
  logic CAL_TAMPER_I, CAL_STAMP_I, USB_WAKE_I, ETH_WAKE_I, WDOG_RESET_I;
  logic EXT_RESET_PIN_N_I, WAKEUP_PIN_I, CORE_RESET_PIN_N_I;
  logic CPU_HALT_O, PERIPH_CLK_EN_O, CORE_CLK_EN_O, PLL_EN_O, INT_OSC_EN_O;
  logic EXT_OSC_EN_O, SLOW_CLK_EN_O, CAL_RUN_O, WDOG_RUN_O, REG_ENABLE_O;
  logic REG_MAIN_O, REG_LOWPOWER_O, REG_POWERDOWN_O, CORE_POWER_EN_O;
  logic CORE_RESET_O, BKP_SRAM_RETAIN_O, BKP_FROM_BAT_O, BAT_MODE_O;
  logic CORE_PIN_GPIO_EN_O, DEBUG_EN_O;
  logic [31:0] r;
  int fails = 0;
  int compares = 0;
  int cycles = 0;

  low_power_mode_wakeup_ctrl uut (.CLK_I, .SYS_RST_I, .ADR_I, .DAT_I,
    .DAT_O, .SEL_I, .WE_I, .CYC_I, .STB_I, .ACK_O, .PERIPH_EVENT_I,
    .EXT_LINE_I, .SUPPLY_DET_I, .CAL_ALARM_I, .CAL_WAKE_I, .CAL_TAMPER_I,
    .CAL_STAMP_I, .USB_WAKE_I, .ETH_WAKE_I, .EXT_RESET_PIN_N_I,
    .WDOG_RESET_I, .WAKEUP_PIN_I, .REG_DISABLE_PIN_I, .CORE_RESET_PIN_N_I,
    .INT_RESET_DISABLE_PIN_I, .MAIN_SUPPLY_OK_I, .CPU_HALT_O,
    .PERIPH_CLK_EN_O, .CORE_CLK_EN_O, .PLL_EN_O, .INT_OSC_EN_O,
    .EXT_OSC_EN_O, .SLOW_CLK_EN_O, .CAL_RUN_O, .WDOG_RUN_O, .REG_ENABLE_O,
    .REG_MAIN_O, .REG_LOWPOWER_O, .REG_POWERDOWN_O, .CORE_POWER_EN_O,
    .CORE_RESET_O, .BKP_SRAM_RETAIN_O, .BKP_FROM_BAT_O, .BAT_MODE_O,
    .CORE_PIN_GPIO_EN_O, .DEBUG_EN_O);

  pwr_partner p (.clk_i(CLK_I), .periph_event_o(PERIPH_EVENT_I),
    .ext_line_o(EXT_LINE_I), .supply_det_o(SUPPLY_DET_I),
    .cal_alarm_o(CAL_ALARM_I), .cal_wake_o(CAL_WAKE_I),
    .cal_tamper_o(CAL_TAMPER_I), .cal_stamp_o(CAL_STAMP_I),
    .usb_wake_o(USB_WAKE_I), .eth_wake_o(ETH_WAKE_I),
    .ext_reset_n_o(EXT_RESET_PIN_N_I), .wdog_reset_o(WDOG_RESET_I),
    .wakeup_pin_o(WAKEUP_PIN_I), .core_reset_n_o(CORE_RESET_PIN_N_I));

  // ****************************************************************
  // Clock, timeout, report
  // ****************************************************************
  initial begin
    forever #2.5 CLK_I = ~CLK_I;
  end

  always @(posedge CLK_I) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ****************************************************************
  // Bus and helpers
  // ****************************************************************
  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge CLK_I);
    chk("ack idle", 0, ACK_O);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    ADR_I <= a;
    WE_I <= w;
    DAT_I <= d;
    SEL_I <= 4'hF;
    do begin
      @(posedge CLK_I);
    end while (ACK_O !== 1'b1);
    q = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    WE_I <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e, input string nm);
    logic [31:0] q;
    wb(a, 1'b0, 32'h0, q);
    chk(nm, e, q & m);
  endtask

  task automatic enter(input logic [1:0] md, input logic lp, input logic ret);
    wb(`PWR_CTRL_OFS, 1'b1, {23'h0, 1'b1, 4'h0, ret, lp, md}, r);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge CLK_I);
    @(negedge CLK_I);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    settle(1);
    chk("restart", 1, CORE_RESET_O);
    settle(25);
    chk("halt", 0, CPU_HALT_O);
    rd(`PWR_STAT_OFS, 32'h7, 32'h0, "state");
    rd(8'hFC, 32'hFFFF_FFFF, 32'h0, "unmapped");
    wb(`PWR_BKP_OFS, 1'b1, 32'h1234_5678, r);
    rd(`PWR_BKP_OFS, 32'hFFFF_FFFF, 32'h1234_5678, "word 0");
    rd(`PWR_BKP_OFS + 8'h50, 32'hFFFF_FFFF, 32'h0, "past end");
  endtask

  task automatic t_sleep();
    enter(2'h0, 1'b0, 1'b0);
    settle(2);
    chk("halt", 1, CPU_HALT_O);
    chk("periph clk", 1, PERIPH_CLK_EN_O);
    p.pulse(26);
    settle(1);
    chk("sleep wake", 0, CPU_HALT_O);
  endtask

  task automatic t_stop();
    for (int s = 0; s < 23; s++) begin
      enter(2'h1, s[0], 1'b0);
      settle(2);
      chk("clocks", 0, {PERIPH_CLK_EN_O, CORE_CLK_EN_O, PLL_EN_O,
        INT_OSC_EN_O, EXT_OSC_EN_O});
      chk("lowpower", s[0], REG_LOWPOWER_O);
      chk("powerdown", 0, REG_POWERDOWN_O);
      chk("always on", 7, {SLOW_CLK_EN_O, CAL_RUN_O, WDOG_RUN_O});
      p.pulse(s);
      settle(1);
      rd(`PWR_STAT_OFS, 32'h17, 32'h10, "stop wake");
      rd(`PWR_CTRL_OFS, 32'h4, {29'h0, s[0], 2'h0}, "kept");
      chk("lowpower run", 0, REG_LOWPOWER_O);
      wb(`PWR_STAT_OFS, 1'b1, 32'h10, r);
    end
  endtask

  task automatic t_standby();
    int src[7] = '{23, 24, 25, 17, 18, 19, 20};
    for (int i = 0; i < 7; i++) begin
      wb(`PWR_BKP_OFS + 8'h4C, 1'b1, 32'hA5A5_0000 + i, r);
      enter(2'h2, 1'b0, i[0]);
      settle(2);
      chk("powerdown", 1, REG_POWERDOWN_O);
      chk("core power", 0, CORE_POWER_EN_O);
      chk("pll", 0, PLL_EN_O);
      chk("retain", i[0], BKP_SRAM_RETAIN_O);
      p.pulse(src[i]);
      settle(1);
      chk("restart", 1, CORE_RESET_O);
      settle(25);
      rd(`PWR_STAT_OFS, 32'hF, 32'h8, "standby exit");
      rd(`PWR_BKP_OFS + 8'h4C, 32'hFFFF_FFFF, 32'hA5A5_0000 + i,
        "backup");
    end
    @(posedge CLK_I) SYS_RST_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
    SYS_RST_I <= 1'b0;
    settle(25);
    rd(`PWR_BKP_OFS + 8'h4C, 32'hFFFF_FFFF, 32'hA5A5_0006,
      "after reset");
  endtask

  task automatic t_battery();
    @(posedge CLK_I) MAIN_SUPPLY_OK_I <= 1'b0;
    settle(2);
    chk("bkp supply", 1, BKP_FROM_BAT_O);
    p.pulse(0);
    p.pulse(17);
    settle(1);
    chk("stay battery", 1, BAT_MODE_O);
    @(posedge CLK_I) INT_RESET_DISABLE_PIN_I <= 1'b1;
    settle(0);
    chk("no battery", 0, BKP_FROM_BAT_O);
    @(posedge CLK_I) MAIN_SUPPLY_OK_I <= 1'b1;
    INT_RESET_DISABLE_PIN_I <= 1'b0;
    settle(25);
    chk("halt", 0, CPU_HALT_O);
  endtask

  task automatic t_regulator_disable_pin();
    @(posedge CLK_I) REG_DISABLE_PIN_I <= 1'b1;
    settle(0);
    chk("reg enable", 0, REG_ENABLE_O);
    chk("reg main", 0, REG_MAIN_O);
    chk("gpio", 0, CORE_PIN_GPIO_EN_O);
    p.hold_core(1'b0);
    settle(0);
    chk("debug", 0, DEBUG_EN_O);
    chk("core reset", 1, CORE_RESET_O);
    p.hold_core(1'b1);
    @(posedge CLK_I) REG_DISABLE_PIN_I <= 1'b0;
    settle(25);
    chk("debug back", 1, DEBUG_EN_O);
  endtask

  initial begin
    repeat (10) @(posedge CLK_I);
    SYS_RST_I <= 1'b0;
    t_reset();
    t_sleep();
    t_stop();
    t_standby();
    t_battery();
    t_regulator_disable_pin();
    give_verdict();
  end
endmodule // testbench
